// ---- hdl/pri_reset_seq.sv ----
// processor reset sequencer: reset sources, cause recording, register init, boot fetch
`include "pri_params.svh"
`default_nettype none

module pri_reset_seq #(
   parameter int unsigned          HOLD_CYCLES = `PRI_HOLD_CYCLES,     // reset hold length
   parameter logic [31:0]          VERSION_ID  = `PRI_VERSION_DEFAULT  // arbitrary value
) (
   input  wire logic                    SYS_CLK,
   input  wire logic                    SYS_RST,
   input  wire logic                    EXT_RST_REQ,
   input  wire logic                    DBG_RST_REQ,
   input  wire logic [1:0]              DBG_RST_SCOPE,
   input  wire logic                    WDOG_SECOND_TIMEOUT,
   input  wire logic [`PRI_ADDR_W-1:0]  REG_ADDR,
   input  wire logic [31:0]             REG_WDATA,
   input  wire logic                    REG_WR,
   input  wire logic                    REG_RD,
   output      logic [31:0]             REG_RDATA,
   input  wire logic                    FETCH_ACK,
   input  wire logic                    FETCH_IS_BRANCH,
   input  wire logic [31:0]             FETCH_TARGET,
   output      logic                    FETCH_REQ,
   output      logic [31:0]             FETCH_ADDR,
   output      logic                    CORE_RUN,
   output      logic                    CORE_RST_OUT,
   output      logic                    CHIP_RST_OUT,
   output      logic                    SYS_RST_OUT
);

   // the counter compares against the last hold cycle, so a hold of zero
   // cycles would wrap to the longest hold; keep HOLD_CYCLES at one or more
   localparam logic [15:0] HOLD_LAST = 16'(HOLD_CYCLES - 1);  // last hold cycle

   pri_pkg::pri_regs_t st_q;     // all state
   pri_pkg::pri_regs_t st_d;     // next state

   logic       req_any;          // some source asks for a reset this cycle
   logic [1:0] req_cause;        // scope of the winning request
   logic [1:0] sw_field;         // software reset field being written
   logic       sw_write;         // write to first debug control register
   logic [1:0] wdog_ctl;         // watchdog reset control field

   // pick the winning reset request; external pins beat everything
   // the software write and the watchdog pulse already live on this clock,
   // so only the pin and debug port requests go through synchronisers
   always_comb begin
      sw_write  = REG_WR && (REG_ADDR == `PRI_OFF_DBG_CTL1);
      sw_field  = REG_WDATA[`PRI_FLD_HI:`PRI_FLD_LO];
      wdog_ctl  = st_q.timer_control_reg[`PRI_FLD_HI:`PRI_FLD_LO];
      req_any   = 1'b0;
      req_cause = `PRI_CAUSE_NONE;
      if (st_q.ext_s2) begin
         // pins reach the whole reset network
         req_any   = 1'b1;
         req_cause = `PRI_CAUSE_SYSTEM;
      end else if (st_q.dbg_s2 && (st_q.dbg_scope_s2 != `PRI_CAUSE_NONE)) begin
         // debug tool names its own scope
         req_any   = 1'b1;
         req_cause = st_q.dbg_scope_s2;
      end else if (sw_write && (sw_field != `PRI_CAUSE_NONE)) begin
         // software picks the scope through the written field value
         req_any   = 1'b1;
         req_cause = sw_field;
      end else if (WDOG_SECOND_TIMEOUT && (wdog_ctl != `PRI_CAUSE_NONE)) begin
         // only when software armed the control field
         req_any   = 1'b1;
         req_cause = wdog_ctl;
      end
   end

   // next-state logic for sequencer, registers and outputs
   always_comb begin
      st_d = st_q;

      // synchronisers; the first stage feeds only the second
      st_d.ext_s1 = EXT_RST_REQ;
      st_d.ext_s2 = st_q.ext_s1;
      st_d.dbg_s1 = DBG_RST_REQ;
      st_d.dbg_s2 = st_q.dbg_s1;
      // scope travels through the same two stages so it lines up with its request
      st_d.dbg_scope_s1 = DBG_RST_SCOPE;
      st_d.dbg_scope_s2 = st_q.dbg_scope_s1;

      // register read: data stands in the next cycle only
      st_d.rdata = `PRI_ZERO_WORD;
      if (REG_RD) begin
         unique case (REG_ADDR)
            `PRI_OFF_MSW:         st_d.rdata = st_q.machine_state_word;
            `PRI_OFF_DBG_CTL1:    st_d.rdata = st_q.debug_control_first;
            `PRI_OFF_DBG_CTL2:    st_d.rdata = st_q.debug_control_second;
            `PRI_OFF_DBG_STAT:    st_d.rdata = st_q.debug_status_reg;
            `PRI_OFF_EXC_SYND:    st_d.rdata = st_q.exception_syndrome_reg;
            `PRI_OFF_INSTR_CACHE: st_d.rdata = st_q.instr_cacheability_reg;
            `PRI_OFF_DATA_CACHE:  st_d.rdata = st_q.data_cacheability_reg;
            `PRI_OFF_GUARDED:     st_d.rdata = st_q.guarded_storage_reg;
            `PRI_OFF_ENDIAN:      st_d.rdata = st_q.endian_attribute_reg;
            `PRI_OFF_USER_ATTR:   st_d.rdata = st_q.user_attribute_reg;
            `PRI_OFF_TIMER_CTL:   st_d.rdata = st_q.timer_control_reg;
            `PRI_OFF_TIMER_STAT:  st_d.rdata = st_q.timer_status_reg;
            `PRI_OFF_VERSION:     st_d.rdata = st_q.version_id_reg;
            `PRI_OFF_SEQ_STATUS:  st_d.rdata = {28'h0000000, st_q.cause, st_q.state};
            default:              st_d.rdata = `PRI_ZERO_WORD;      // unmapped reads zero
         endcase
      end

      // register write; cause fields are read-only to software
      if (REG_WR) begin
         unique case (REG_ADDR)
            `PRI_OFF_MSW:         st_d.machine_state_word     = REG_WDATA;
            `PRI_OFF_DBG_CTL1:    st_d.debug_control_first    = REG_WDATA;
            `PRI_OFF_DBG_CTL2:    st_d.debug_control_second   = REG_WDATA;
            `PRI_OFF_DBG_STAT: begin
               // event bits written freely, last cause kept
               st_d.debug_status_reg = REG_WDATA;
               st_d.debug_status_reg[`PRI_FLD_HI:`PRI_FLD_LO] =
                  st_q.debug_status_reg[`PRI_FLD_HI:`PRI_FLD_LO];
            end
            `PRI_OFF_EXC_SYND:    st_d.exception_syndrome_reg = REG_WDATA;
            `PRI_OFF_INSTR_CACHE: st_d.instr_cacheability_reg = REG_WDATA;
            `PRI_OFF_DATA_CACHE:  st_d.data_cacheability_reg  = REG_WDATA;
            `PRI_OFF_GUARDED:     st_d.guarded_storage_reg    = REG_WDATA;
            `PRI_OFF_ENDIAN:      st_d.endian_attribute_reg   = REG_WDATA;
            `PRI_OFF_USER_ATTR:   st_d.user_attribute_reg     = REG_WDATA;
            `PRI_OFF_TIMER_CTL:   st_d.timer_control_reg      = REG_WDATA;
            `PRI_OFF_TIMER_STAT: begin
               // watchdog cause kept so software can still read it
               st_d.timer_status_reg = REG_WDATA;
               st_d.timer_status_reg[`PRI_FLD_HI:`PRI_FLD_LO] =
                  st_q.timer_status_reg[`PRI_FLD_HI:`PRI_FLD_LO];
            end
            default: ;                                              // version and status read-only
         endcase
      end

      // sequencer
      // one init cycle loads every defined register at once, so the scope of
      // the reset can never change what gets written, only the recorded cause
      unique case (st_q.state)
         pri_pkg::PRI_HOLD: begin
            // scope outputs held; pins keep us here while they stay high
            if (st_q.ext_s2) begin
               st_d.hold_cnt = 16'h0000;
               st_d.cause    = `PRI_CAUSE_SYSTEM;
            end else if (st_q.hold_cnt >= HOLD_LAST) begin
               st_d.state = pri_pkg::PRI_INIT;
            end else begin
               st_d.hold_cnt = st_q.hold_cnt + 16'h0001;
            end
         end
         pri_pkg::PRI_INIT: begin
            // identical init for every scope; only the cause differs
            st_d.machine_state_word     = `PRI_ZERO_WORD;
            st_d.debug_control_first    = `PRI_ZERO_WORD;
            st_d.debug_control_second   = `PRI_ZERO_WORD;
            st_d.exception_syndrome_reg = `PRI_ZERO_WORD;
            st_d.instr_cacheability_reg = `PRI_ZERO_WORD;
            st_d.data_cacheability_reg  = `PRI_ZERO_WORD;
            st_d.guarded_storage_reg    = `PRI_ALL_GUARDED;
            st_d.endian_attribute_reg   = `PRI_ZERO_WORD;
            st_d.user_attribute_reg     = `PRI_ZERO_WORD;
            st_d.timer_control_reg[`PRI_FLD_HI:`PRI_FLD_LO] = `PRI_CAUSE_NONE;
            st_d.debug_status_reg[`PRI_FLD_HI:`PRI_FLD_LO]  = st_q.cause;
            st_d.version_id_reg         = VERSION_ID;
            // registers without a defined reset value keep what they hold
            // release the scope outputs and start the boot fetch
            st_d.core_rst   = 1'b0;
            st_d.chip_rst   = 1'b0;
            st_d.sys_rst    = 1'b0;
            st_d.fetch_addr = `PRI_BOOT_ADDR;
            st_d.fetch_req  = 1'b1;
            st_d.state      = pri_pkg::PRI_FETCH;
         end
         pri_pkg::PRI_FETCH: begin
            // first instruction returned by boot memory
            if (FETCH_ACK) begin
               st_d.fetch_req = 1'b0;
               st_d.core_run  = 1'b1;
               st_d.state     = pri_pkg::PRI_RUN;
               if (FETCH_IS_BRANCH) begin
                  st_d.fetch_addr = FETCH_TARGET;
               end else begin
                  // top word plus four rolls over to zero by width
                  st_d.fetch_addr = st_q.fetch_addr + `PRI_FETCH_STEP;
               end
            end
         end
         pri_pkg::PRI_RUN: begin
            st_d.core_run = 1'b1;
         end
      endcase

      // a new request outside the hold state aborts init, fetch or run at once
      if (req_any && (st_q.state != pri_pkg::PRI_HOLD)) begin
         st_d.state     = pri_pkg::PRI_HOLD;
         st_d.hold_cnt  = 16'h0000;
         st_d.cause     = req_cause;
         st_d.core_run  = 1'b0;
         st_d.fetch_req = 1'b0;
         st_d.core_rst  = 1'b1;
         st_d.chip_rst  = (req_cause != `PRI_CAUSE_CORE);
         st_d.sys_rst   = (req_cause == `PRI_CAUSE_SYSTEM);
         // watchdog cause only when the watchdog won, else 00
         st_d.timer_status_reg[`PRI_FLD_HI:`PRI_FLD_LO] =
            (!st_q.ext_s2 && !(st_q.dbg_s2 && (st_q.dbg_scope_s2 != `PRI_CAUSE_NONE)) &&
             !(sw_write && (sw_field != `PRI_CAUSE_NONE))) ?
            req_cause : `PRI_CAUSE_NONE;
      end else if ((st_q.state == pri_pkg::PRI_HOLD) && st_q.ext_s2) begin
         // pins widen any reset already in progress
         st_d.chip_rst = 1'b1;
         st_d.sys_rst  = 1'b1;
         st_d.timer_status_reg[`PRI_FLD_HI:`PRI_FLD_LO] = `PRI_CAUSE_NONE;
      end
   end

   // state register; power-up counts as a system reset
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         st_q.state                  <= pri_pkg::PRI_HOLD;
         st_q.hold_cnt               <= 16'h0000;
         st_q.cause                  <= `PRI_CAUSE_SYSTEM;
         st_q.ext_s1                 <= 1'b0;
         st_q.ext_s2                 <= 1'b0;
         st_q.dbg_s1                 <= 1'b0;
         st_q.dbg_s2                 <= 1'b0;
         st_q.dbg_scope_s1           <= `PRI_CAUSE_NONE;
         st_q.dbg_scope_s2           <= `PRI_CAUSE_NONE;
         st_q.machine_state_word     <= `PRI_ZERO_WORD;
         st_q.debug_control_first    <= `PRI_ZERO_WORD;
         st_q.debug_control_second   <= `PRI_ZERO_WORD;
         st_q.debug_status_reg       <= `PRI_ZERO_WORD;
         st_q.exception_syndrome_reg <= `PRI_ZERO_WORD;
         st_q.instr_cacheability_reg <= `PRI_ZERO_WORD;
         st_q.data_cacheability_reg  <= `PRI_ZERO_WORD;
         st_q.guarded_storage_reg    <= `PRI_ALL_GUARDED;
         st_q.endian_attribute_reg   <= `PRI_ZERO_WORD;
         st_q.user_attribute_reg     <= `PRI_ZERO_WORD;
         // other timer bits are undefined; zero keeps simulation clean
         st_q.timer_control_reg      <= `PRI_ZERO_WORD;
         st_q.timer_status_reg       <= `PRI_ZERO_WORD;
         st_q.version_id_reg         <= VERSION_ID;
         st_q.fetch_addr             <= `PRI_BOOT_ADDR;
         st_q.fetch_req              <= 1'b0;
         st_q.core_run               <= 1'b0;
         st_q.core_rst               <= 1'b1;
         st_q.chip_rst               <= 1'b1;
         st_q.sys_rst                <= 1'b1;
         st_q.rdata                  <= `PRI_ZERO_WORD;
      end else begin
         st_q <= st_d;
      end
   end

   // outputs straight from flops
   assign REG_RDATA    = st_q.rdata;
   assign FETCH_REQ    = st_q.fetch_req;
   assign FETCH_ADDR   = st_q.fetch_addr;
   assign CORE_RUN     = st_q.core_run;
   assign CORE_RST_OUT = st_q.core_rst;
   assign CHIP_RST_OUT = st_q.chip_rst;
   assign SYS_RST_OUT  = st_q.sys_rst;

endmodule : pri_reset_seq
`default_nettype wire

// ---- inc/pri_params.svh ----
// constants for the processor reset and initialisation sequencer
`ifndef PRI_PARAMS_SVH
`define PRI_PARAMS_SVH

// register port
`define PRI_ADDR_W          8
`define PRI_OFF_MSW         8'h00
`define PRI_OFF_DBG_CTL1    8'h04
`define PRI_OFF_DBG_CTL2    8'h08
`define PRI_OFF_DBG_STAT    8'h0c
`define PRI_OFF_EXC_SYND    8'h10
`define PRI_OFF_INSTR_CACHE 8'h14
`define PRI_OFF_DATA_CACHE  8'h18
`define PRI_OFF_GUARDED     8'h1c
`define PRI_OFF_ENDIAN      8'h20
`define PRI_OFF_USER_ATTR   8'h24
`define PRI_OFF_TIMER_CTL   8'h28
`define PRI_OFF_TIMER_STAT  8'h2c
`define PRI_OFF_VERSION     8'h30
`define PRI_OFF_SEQ_STATUS  8'h34

// two-bit fields: software reset request, last reset cause, watchdog control and cause
`define PRI_FLD_HI          29
`define PRI_FLD_LO          28

// reset values
`define PRI_ZERO_WORD       32'h0000_0000
`define PRI_ALL_GUARDED     32'hffff_ffff
`define PRI_BOOT_ADDR       32'hffff_fffc
`define PRI_FETCH_STEP      32'h0000_0004
`define PRI_VERSION_DEFAULT 32'h0000_1234

// cause codes
`define PRI_CAUSE_NONE      2'h0
`define PRI_CAUSE_CORE      2'h1
`define PRI_CAUSE_CHIP      2'h2
`define PRI_CAUSE_SYSTEM    2'h3

// timing
`define PRI_CLK_PERIOD_NS   10
`define PRI_HOLD_NS         160
`define PRI_HOLD_CYCLES     ((`PRI_HOLD_NS + `PRI_CLK_PERIOD_NS - 1) / `PRI_CLK_PERIOD_NS)
`define PRI_CNT_W           16

`endif

// ---- inc/pri_pkg.sv ----
// types for the processor reset and initialisation sequencer
`default_nettype none
package pri_pkg;

   // gray coded: hold -> init -> fetch -> run -> hold
   typedef enum logic [1:0] {
      PRI_HOLD  = 2'h0,
      PRI_INIT  = 2'h1,
      PRI_FETCH = 2'h3,
      PRI_RUN   = 2'h2
   } pri_state_t;

   typedef struct packed {
      pri_state_t  state;        // sequencer state
      logic [15:0] hold_cnt;     // cycles spent holding reset
      logic [1:0]  cause;        // scope of the reset in progress
      logic        ext_s1;       // external reset, first sync stage
      logic        ext_s2;       // external reset, second sync stage
      logic        dbg_s1;       // debug port request, first sync stage
      logic        dbg_s2;       // debug port request, second sync stage
      logic [1:0]  dbg_scope_s1; // debug port scope, first sync stage
      logic [1:0]  dbg_scope_s2; // debug port scope, second sync stage
      logic [31:0] machine_state_word;
      logic [31:0] debug_control_first;
      logic [31:0] debug_control_second;
      logic [31:0] debug_status_reg;
      logic [31:0] exception_syndrome_reg;
      logic [31:0] instr_cacheability_reg;
      logic [31:0] data_cacheability_reg;
      logic [31:0] guarded_storage_reg;
      logic [31:0] endian_attribute_reg;
      logic [31:0] user_attribute_reg;
      logic [31:0] timer_control_reg;
      logic [31:0] timer_status_reg;
      logic [31:0] version_id_reg;
      logic [31:0] fetch_addr;   // address of the fetch in flight / next pc
      logic        fetch_req;    // boot fetch outstanding
      logic        core_run;     // core may execute
      logic        core_rst;     // execution and cache units held
      logic        chip_rst;     // on-chip peripherals held
      logic        sys_rst;      // system reset network driven
      logic [31:0] rdata;        // register read data
   } pri_regs_t;

endpackage : pri_pkg
`default_nettype wire

// ---- verif/pri_boot_mem.sv ----
// boot memory model answering the first instruction fetch
`default_nettype none
module pri_boot_mem (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        req,
   input  wire logic [1:0]  dly,
   input  wire logic        br,
   input  wire logic [31:0] tgt,
   output var  logic        ack,
   output var  logic        is_branch,
   output var  logic [31:0] target
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] wait_q;  // cycles waited on this fetch
   // answer after dly cycles; fields toggle outside the answer so a stale value never looks valid
   always_ff @(posedge clk) begin
      if (rst) begin
         wait_q    <= 2'h0;
         ack       <= 1'b0;
         is_branch <= 1'b0;
         target    <= 32'h0000_0000;
      end else if (!req || ack) begin
         wait_q    <= 2'h0;
         ack       <= 1'b0;
         is_branch <= ~is_branch;
         target    <= ~target;
      end else if (wait_q == dly) begin
         ack       <= 1'b1;
         is_branch <= br;   // first big-endian word of boot code
         target    <= tgt;
      end else begin
         wait_q    <= wait_q + 2'h1;
         is_branch <= ~is_branch;
         target    <= ~target;
      end
   end
endmodule : pri_boot_mem
`default_nettype wire

// ---- verif/pri_reset_seq_checker.sv ----
// port-level assertions for the reset sequencer
`include "pri_params.svh"
`default_nettype none
module pri_reset_seq_checker (
   input wire logic        SYS_CLK,
   input wire logic        SYS_RST,
   input wire logic        EXT_RST_REQ,
   input wire logic        DBG_RST_REQ,
   input wire logic [1:0]  DBG_RST_SCOPE,
   input wire logic [7:0]  REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic        REG_WR,
   input wire logic        REG_RD,
   input wire logic [31:0] REG_RDATA,
   input wire logic        FETCH_ACK,
   input wire logic        FETCH_IS_BRANCH,
   input wire logic [31:0] FETCH_TARGET,
   input wire logic        FETCH_REQ,
   input wire logic [31:0] FETCH_ADDR,
   input wire logic        CORE_RUN,
   input wire logic        CORE_RST_OUT,
   input wire logic        CHIP_RST_OUT,
   input wire logic        SYS_RST_OUT
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);
   // a nonzero software field while running must stop the core on the next edge
   chk_sw_halt: assert property (
      CORE_RUN && REG_WR && REG_ADDR == `PRI_OFF_DBG_CTL1 && REG_WDATA[29:28] != 2'h0
      |=> !CORE_RUN && CORE_RST_OUT) else $error("software reset did not halt");
   chk_run_gate: assert property (CORE_RUN |-> !CORE_RST_OUT && !FETCH_REQ)
      else $error("core runs while held");
   // wider scopes always include the narrower ones
   chk_scope_nest: assert property ((SYS_RST_OUT |-> CHIP_RST_OUT) and (CHIP_RST_OUT |-> CORE_RST_OUT))
      else $error("reset scopes not nested");
   // two sync stages plus one registered edge
   chk_ext_system: assert property (EXT_RST_REQ [*3] |-> ##[1:2] SYS_RST_OUT)
      else $error("external reset not system wide");
   chk_dbg_take: assert property (
      (DBG_RST_REQ && DBG_RST_SCOPE != 2'h0 && CORE_RUN) [*3] |-> ##[1:2] CORE_RST_OUT)
      else $error("debug request ignored");
   chk_boot_addr: assert property ($fell(CORE_RST_OUT) |-> ##[0:1] FETCH_REQ && FETCH_ADDR == `PRI_BOOT_ADDR)
      else $error("first fetch not at top word");
   chk_wrap_zero: assert property (
      FETCH_REQ && FETCH_ACK && !FETCH_IS_BRANCH |=> CORE_RUN && FETCH_ADDR == `PRI_ZERO_WORD)
      else $error("no wrap to zero");
   chk_branch_tgt: assert property (
      FETCH_REQ && FETCH_ACK && FETCH_IS_BRANCH |=> CORE_RUN && FETCH_ADDR == $past(FETCH_TARGET))
      else $error("branch target not taken");
   chk_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0000_0000)
      else $error("read data outside its cycle");
endmodule : pri_reset_seq_checker
bind pri_reset_seq pri_reset_seq_checker chk_u (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .EXT_RST_REQ(EXT_RST_REQ),
   .DBG_RST_REQ(DBG_RST_REQ), .DBG_RST_SCOPE(DBG_RST_SCOPE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
   .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .FETCH_ACK(FETCH_ACK), .FETCH_IS_BRANCH(FETCH_IS_BRANCH),
   .FETCH_TARGET(FETCH_TARGET), .FETCH_REQ(FETCH_REQ), .FETCH_ADDR(FETCH_ADDR), .CORE_RUN(CORE_RUN),
   .CORE_RST_OUT(CORE_RST_OUT), .CHIP_RST_OUT(CHIP_RST_OUT), .SYS_RST_OUT(SYS_RST_OUT));
`default_nettype wire

// ---- verif/pri_reset_seq_tb_top.sv ----
// self-checking bench for the reset sequencer
`include "pri_params.svh"
`default_nettype none
module pri_reset_seq_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] VER = 32'h0000_5a5a;  // arbitrary version value
   logic        clk = 1'b0, rst = 1'b1, ext = 1'b0, dbg = 1'b0, wdog = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
   logic [1:0]  scope = 2'h1, dly = 2'h0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, faddr, tgt = 32'h0, ftgt;
   logic        br = 1'b0, ack, fbr, freq, run, core_o, chip_o, sys_o;
   int          bad_count = 0, cmp_count = 0;
   logic [7:0]  offs [9] = '{`PRI_OFF_MSW, `PRI_OFF_DBG_CTL1, `PRI_OFF_DBG_CTL2, `PRI_OFF_EXC_SYND,
      `PRI_OFF_INSTR_CACHE, `PRI_OFF_DATA_CACHE, `PRI_OFF_GUARDED, `PRI_OFF_ENDIAN, `PRI_OFF_USER_ATTR};
   always #5 clk = ~clk;
   pri_reset_seq #(.HOLD_CYCLES(2), .VERSION_ID(VER)) dut_u (.SYS_CLK(clk), .SYS_RST(rst), .EXT_RST_REQ(ext),
      .DBG_RST_REQ(dbg), .DBG_RST_SCOPE(scope), .WDOG_SECOND_TIMEOUT(wdog), .REG_ADDR(addr), .REG_WDATA(wdata),
      .REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdata), .FETCH_ACK(ack), .FETCH_IS_BRANCH(fbr),
      .FETCH_TARGET(ftgt), .FETCH_REQ(freq), .FETCH_ADDR(faddr), .CORE_RUN(run), .CORE_RST_OUT(core_o),
      .CHIP_RST_OUT(chip_o), .SYS_RST_OUT(sys_o));
   pri_boot_mem mem_u (.clk(clk), .rst(rst), .req(freq), .dly(dly), .br(br), .tgt(tgt), .ack(ack),
      .is_branch(fbr), .target(ftgt));
   // value each initialised register must hold after any reset
   function automatic logic [31:0] exp_init(input logic [7:0] a);
      return (a == `PRI_OFF_GUARDED) ? `PRI_ALL_GUARDED : `PRI_ZERO_WORD;
   endfunction : exp_init
   task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask : cmp
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr_s  <= 1'b1;
      @(posedge clk);
      wr_s  <= 1'b0;
   endtask : wr
   // data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 d = rdata;
   endtask : rd
   // wait for the boot fetch, let the memory answer at a random pace
   task automatic boot();
      int n;
      br  <= 1'($urandom);
      tgt <= $urandom & 32'hffff_fffc;
      dly <= 2'($urandom);
      for (n = 0; freq !== 1'b1 && n < 60; n++) @(posedge clk) #1;
      cmp("fetch req", 32'h1, {31'h0, freq});
      cmp("fetch addr", `PRI_BOOT_ADDR, faddr);
      for (n = 0; freq !== 1'b0 && n < 10; n++) @(posedge clk) #1;
      cmp("next pc", br ? tgt : `PRI_ZERO_WORD, faddr);
      cmp("core run", 32'h1, {31'h0, run});
   endtask : boot
   task automatic check_init(input logic [1:0] c, input logic [1:0] wc);
      logic [31:0] d;
      foreach (offs[i]) begin
         rd(offs[i], d);
         cmp("init value", exp_init(offs[i]), d);
      end
      rd(`PRI_OFF_DBG_STAT, d);
      cmp("last cause", {30'h0, c}, {30'h0, d[29:28]});
      rd(`PRI_OFF_TIMER_STAT, d);
      cmp("watchdog cause", {30'h0, wc}, {30'h0, d[29:28]});
      rd(`PRI_OFF_TIMER_CTL, d);
      cmp("watchdog ctl", 32'h0, {30'h0, d[29:28]});
      rd(`PRI_OFF_VERSION, d);
      cmp("version", VER, d);
      rd(`PRI_OFF_SEQ_STATUS, d);
      cmp("seq status", {28'h0, c, pri_pkg::PRI_RUN}, d);
      rd(8'h40, d);
      cmp("unmapped", 32'h0, d);
   endtask : check_init
   // dirty the initialised registers and timer control, then reset from source s (0 sw, 1 debug, 2 pins, 3 watchdog)
   task automatic hit(input int s, input logic [1:0] sc);
      int n;
      logic [1:0] c;
      c = (s == 2) ? 2'h3 : sc;
      foreach (offs[i]) wr(offs[i], (i == 1) ? ($urandom & 32'hcfff_ffff) : $urandom);
      wr(`PRI_OFF_TIMER_CTL, (s == 3) ? {2'h0, sc, 28'h0} : 32'h0);
      case (s)
         0: wr(`PRI_OFF_DBG_CTL1, {2'h0, sc, 28'h0});
         1: begin
            scope <= sc;
            dbg   <= 1'b1;
         end
         2: ext <= 1'b1;
         default: begin
            wdog <= 1'b1;
            @(posedge clk);
            wdog <= 1'b0;
         end
      endcase
      for (n = 0; core_o !== 1'b1 && n < 8; n++) @(posedge clk) #1;
      cmp("scope outs", {29'h0, c == 2'h3, c[1], 1'b1}, {29'h0, sys_o, chip_o, core_o});
      cmp("halted", 32'h0, {31'h0, run});
      dbg <= 1'b0;
      ext <= 1'b0;
      boot();
      check_init(c, (s == 3) ? sc : 2'h0);
      $display("test source %0d scope %0d done", s, sc);
   endtask : hit
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_of_test
   initial begin
      #100us;
      bad_count++;
      end_of_test();
   end
   initial begin
      void'($urandom(32'h01df));
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      boot();
      check_init(2'h3, 2'h0);
      $display("test power-up done");
      for (int s = 0; s < 4; s++) begin
         for (int c = 1; c < 4; c++) begin
            if (s != 2 || c == 3) hit(s, 2'(c));
         end
      end
      // control field is clear now, so a timeout must be harmless
      @(posedge clk);
      wdog <= 1'b1;
      @(posedge clk);
      wdog <= 1'b0;
      repeat (4) @(posedge clk);
      #1 cmp("still running", 32'h1, {31'h0, run});
      $display("test watchdog disarmed done");
      end_of_test();
   end
endmodule : pri_reset_seq_tb_top
`default_nettype wire
